// ### hw/pmc_pkg.sv
package pmc_pkg;
    // slow timebase tick rate and derived interval counts
    localparam int TICK_HZ = 1000;                 // 1 ms tick
    localparam int CLK_HZ = 250000000;
    localparam int TICK_DIV = CLK_HZ / TICK_HZ;    // clocks per tick
    localparam int QUIET_MS = 1;                   // longest, rounds down
    localparam int QUIET_TICKS = (QUIET_MS * TICK_HZ) / 1000;
    localparam int REC_SC_S = 2;
    localparam int REC_SC_TICKS = REC_SC_S * TICK_HZ;
    localparam int SAMPLE_MS = 2;
    localparam int SAMPLE_TICKS = (SAMPLE_MS * TICK_HZ) / 1000;
    localparam int HOST_UP_MS = 5;
    localparam int HOST_UP_TICKS = (HOST_UP_MS * TICK_HZ) / 1000;
    localparam int DGL_SC_TICKS = 1;               // plain default
    localparam int DGL_CUT_TICKS = 1;              // plain default
    localparam int WAKE1_MIN_MS = 80;
    localparam int WAKE1_MAX_MS = 1000;
    localparam int TMR_W = 12;
    // cell level code: 2 % steps from 60 % to 100 %
    localparam int LVL_W = 5;
    localparam logic [LVL_W-1:0] LVL_RST = 5'h00;

    typedef enum logic [2:0] {
        PMC_ACTIVE  = 3'b000,
        PMC_QUIET   = 3'b001,
        PMC_SHIP    = 3'b010,
        PMC_WAKING  = 3'b011,
        PMC_HIGH_Z  = 3'b100,
        PMC_SAMPLE  = 3'b101
    } pmc_state_e;
endpackage : pmc_pkg

// ### hw/pmc_tick.sv
`timescale 1ns/1ps
// divides the fast clock into a one-cycle slow tick
module pmc_tick
    import pmc_pkg::*;
#(
    parameter int DIV = TICK_DIV
) (
    input wire logic CLK,
    input wire logic RSTN,
    output logic TICK
);
    logic [31:0] cnt_r;

    // free-running divider
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cnt_r <= 32'h0;
            TICK <= 1'b0;
        end else begin
            TICK <= (cnt_r == 32'(DIV - 1));
            cnt_r <= (cnt_r == 32'(DIV - 1)) ? 32'h0 : cnt_r + 32'h1;
        end
    end
endmodule : pmc_tick

// ### hw/pmc_timer.sv
`timescale 1ns/1ps
// tick counter that restarts whenever its condition drops
module pmc_timer
    import pmc_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic TICK,
    input wire logic RUN,
    input wire logic [TMR_W-1:0] LIMIT,
    output logic DONE
);
    logic [TMR_W-1:0] cnt_r;

    // count ticks while run holds, clear otherwise
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cnt_r <= '0;
        end else if (!RUN) begin
            cnt_r <= '0;
        end else if (TICK && cnt_r < LIMIT) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign DONE = RUN && (cnt_r >= LIMIT);
endmodule : pmc_timer

// ### hw/pmc_ctrl.sv
`timescale 1ns/1ps
module pmc_ctrl
    import pmc_pkg::*;
#(
    parameter int REC_TICKS = REC_SC_TICKS,
    parameter int DIV = TICK_DIV
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic INPUT_VALID,
    input wire logic INPUT_ABOVE_SLEEP,
    input wire logic CHARGE_DISABLE_N,
    input wire logic PUSHBUTTON_N,
    input wire logic BUTTON_ACTION_SELECT,
    input wire logic LONG_PRESS_DONE,
    input wire logic [TMR_W-1:0] WAKE1_MS,
    input wire logic SHIP_REQUEST_SET,
    input wire logic SHIP_REQUEST_CLR,
    input wire logic HIGH_Z_REQUEST_SET,
    input wire logic CHARGE_INHIBIT,
    input wire logic AUX_BUS_ENABLE,
    input wire logic AUX_OUTPUT_CONTROL,
    input wire logic CELL_ABOVE_CUTOFF,
    input wire logic CELL_ABOVE_RELEASE,
    input wire logic CELL_ABOVE_MIN_CUTOFF,
    input wire logic CELL_ABOVE_MAX_CUTOFF,
    input wire logic SHORT_LIMIT,
    input wire logic RAIL_IN_LEVEL,
    input wire logic CELL_SAMPLE_TRIGGER,
    input wire logic [LVL_W-1:0] CELL_LEVEL_IN,
    output logic SHIP_REQUEST_BIT,
    output logic SHIP_MODE,
    output logic HIGH_Z_MODE,
    output logic MID_PULLDOWN,
    output logic DISCHARGE_FET_ON,
    output logic SUPPLEMENT_FET_ON,
    output logic RAIL_ENABLE,
    output logic CHARGE_ENABLE,
    output logic AUX_SWITCH_OUTPUT,
    output logic SERIAL_ENABLE,
    output logic HOST_IF_READY,
    output logic SAMPLE_BUSY,
    output logic [LVL_W-1:0] CELL_LEVEL_FIELD
);
    pmc_state_e state_r;
    logic tick;
    logic ship_req_r;
    logic ship_armed_r;
    logic aux_latched_r;
    logic serial_off_r;
    logic cd_prev_r;
    logic fet_r;
    logic rail_r;
    logic in_short_rec_r;
    logic sample_auto_r;
    logic [LVL_W-1:0] level_r;
    logic entry_cond;
    logic quiet_done;
    logic wake_done;
    logic dgl_done;
    logic sc_done;
    logic rec_done;
    logic smp_done;
    logic host_done;
    logic long_press_ship;
    logic wake_btn_r;
    logic cd_toggle;

    pmc_tick #(.DIV(DIV)) u_tick (.CLK(CLK), .RSTN(RSTN), .TICK(tick));

    // entry conditions, input must be below lockout
    assign entry_cond = !INPUT_VALID && CHARGE_DISABLE_N && PUSHBUTTON_N;
    // long press only counts with action select 0
    assign long_press_ship = LONG_PRESS_DONE && !BUTTON_ACTION_SELECT;
    assign cd_toggle = CHARGE_DISABLE_N != cd_prev_r;

    // quiet interval, restarted if a condition changes
    pmc_timer u_quiet (.CLK(CLK), .RSTN(RSTN), .TICK(tick),
        .RUN(state_r == PMC_QUIET && entry_cond),
        .LIMIT(TMR_W'(QUIET_TICKS)), .DONE(quiet_done));
    // wake1 hold, counted while button stays low
    pmc_timer u_wake (.CLK(CLK), .RSTN(RSTN), .TICK(tick),
        .RUN(!PUSHBUTTON_N), .LIMIT(WAKE1_MS), .DONE(wake_done));
    pmc_timer u_dgl (.CLK(CLK), .RSTN(RSTN), .TICK(tick),
        .RUN(CELL_ABOVE_CUTOFF && fet_r),
        .LIMIT(TMR_W'(DGL_CUT_TICKS)), .DONE(dgl_done));
    pmc_timer u_sc (.CLK(CLK), .RSTN(RSTN), .TICK(tick),
        .RUN(SHORT_LIMIT && fet_r && !in_short_rec_r),
        .LIMIT(TMR_W'(DGL_SC_TICKS)), .DONE(sc_done));
    pmc_timer u_rec (.CLK(CLK), .RSTN(RSTN), .TICK(tick), .RUN(in_short_rec_r),
        .LIMIT(TMR_W'(REC_TICKS)), .DONE(rec_done));
    pmc_timer u_smp (.CLK(CLK), .RSTN(RSTN), .TICK(tick), .RUN(state_r == PMC_SAMPLE),
        .LIMIT(TMR_W'(SAMPLE_TICKS)), .DONE(smp_done));
    // host interface ready after rail in level
    pmc_timer u_host (.CLK(CLK), .RSTN(RSTN), .TICK(tick),
        .RUN(RAIL_IN_LEVEL && rail_r),
        .LIMIT(TMR_W'(HOST_UP_TICKS)), .DONE(host_done));

    // ship request bit: set wins over clear, clear request only while input valid, ship state clears it too
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ship_req_r <= 1'b0;
        end else if (SHIP_REQUEST_SET) begin
            ship_req_r <= 1'b1;
        end else if (SHIP_REQUEST_CLR && INPUT_VALID) begin
            ship_req_r <= 1'b0;
        end else if (state_r == PMC_SHIP) begin
            ship_req_r <= 1'b0;
        end
    end

    // adapter during held button right after long press arms ship
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ship_armed_r <= 1'b0;
            wake_btn_r <= 1'b0;
        end else begin
            wake_btn_r <= wake_done;
            if (INPUT_VALID && LONG_PRESS_DONE && !PUSHBUTTON_N && !wake_btn_r
                && !BUTTON_ACTION_SELECT) begin
                ship_armed_r <= 1'b1;
            end else if (state_r == PMC_SHIP) begin
                ship_armed_r <= 1'b0;
            end
        end
    end

    // main mode sequencer
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_r <= PMC_ACTIVE;
            sample_auto_r <= 1'b0;
        end else begin
            unique case (state_r)
                PMC_ACTIVE: begin
                    // ship request sources; refused with input present
                    if (entry_cond && (ship_req_r || ship_armed_r || long_press_ship)) begin
                        state_r <= PMC_QUIET;
                    // automatic sample before high-z; pin low or high-z bit
                    end else if (!INPUT_VALID && (!CHARGE_DISABLE_N || HIGH_Z_REQUEST_SET)) begin
                        state_r <= PMC_SAMPLE;
                        sample_auto_r <= 1'b1;
                    end else if (CELL_SAMPLE_TRIGGER) begin
                        state_r <= PMC_SAMPLE;
                        sample_auto_r <= 1'b0;
                    end
                end
                PMC_QUIET: begin
                    if (!entry_cond) begin
                        state_r <= PMC_ACTIVE;
                    end else if (quiet_done) begin
                        state_r <= PMC_SHIP;
                    end
                end
                PMC_SHIP: begin
                    // adapter wake; button needs cell above top cutoff
                    if (INPUT_ABOVE_SLEEP) begin
                        state_r <= PMC_ACTIVE;
                    end else if (!PUSHBUTTON_N && CELL_ABOVE_MAX_CUTOFF) begin
                        state_r <= PMC_WAKING;
                    end
                end
                PMC_WAKING: begin
                    // exit completes only after wake1 hold, else back
                    if (wake_done) begin
                        state_r <= PMC_ACTIVE;
                    end else if (PUSHBUTTON_N) begin
                        state_r <= PMC_SHIP;
                    end
                end
                PMC_SAMPLE: begin
                    if (smp_done) begin
                        state_r <= sample_auto_r ? PMC_HIGH_Z : PMC_ACTIVE;
                    end
                end
                PMC_HIGH_Z: begin
                    // pin toggle or valid input leaves high-z
                    if (INPUT_VALID || cd_toggle) begin
                        state_r <= PMC_ACTIVE;
                    end
                end
                default: state_r <= PMC_ACTIVE;
            endcase
        end
    end

    // sampled cell level latched at end of sample window
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            level_r <= LVL_RST;
        end else if (state_r == PMC_SAMPLE && smp_done) begin
            level_r <= CELL_LEVEL_IN;
        end
    end

    // remember bus enable of the aux output at high-z entry
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            aux_latched_r <= 1'b0;
        end else if (state_r != PMC_HIGH_Z) begin
            aux_latched_r <= AUX_BUS_ENABLE;
        end
    end

    // serial bus off after high-z bit with cell only, until pin toggles
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            serial_off_r <= 1'b0;
            cd_prev_r <= 1'b0; // matches the pin's pull-down idle level
        end else begin
            cd_prev_r <= CHARGE_DISABLE_N;
            if (HIGH_Z_REQUEST_SET && !INPUT_VALID) begin
                serial_off_r <= 1'b1;
            end else if (cd_toggle) begin
                serial_off_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            in_short_rec_r <= 1'b0;
        end else if (sc_done) begin
            in_short_rec_r <= 1'b1;
        end else if (rec_done) begin
            in_short_rec_r <= 1'b0;
        end
    end

    // discharge FET with cutoff hysteresis; held off in ship
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            fet_r <= 1'b0;
        end else if (state_r == PMC_SHIP || state_r == PMC_QUIET || in_short_rec_r
                     || sc_done) begin
            fet_r <= 1'b0;
        // valid input: supplement path above minimum cutoff
        end else if (INPUT_VALID) begin
            fet_r <= CELL_ABOVE_MIN_CUTOFF;
        end else if (!CELL_ABOVE_CUTOFF) begin
            fet_r <= 1'b0;
        // cell above release turns the FET on, or above cutoff while waking
        end else if (CELL_ABOVE_RELEASE || !fet_r) begin
            fet_r <= CELL_ABOVE_RELEASE || (state_r == PMC_WAKING);
        end
    end

    // rail starts after cutoff deglitch; kept up in high-z
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rail_r <= 1'b0;
        end else if (state_r == PMC_SHIP || state_r == PMC_QUIET) begin
            rail_r <= 1'b0;
        end else if (INPUT_VALID || dgl_done) begin
            rail_r <= 1'b1;
        end else if (!fet_r) begin
            rail_r <= 1'b0;
        end
    end

    // ship mode outputs and mid pull-down
    assign SHIP_MODE = state_r == PMC_SHIP || state_r == PMC_WAKING;
    assign MID_PULLDOWN = state_r == PMC_SHIP;
    assign HIGH_Z_MODE = state_r == PMC_HIGH_Z;
    assign SHIP_REQUEST_BIT = ship_req_r;
    // masked in ship so a dropped wake attempt cannot leak one cycle
    assign DISCHARGE_FET_ON = (fet_r && state_r != PMC_SHIP) || state_r == PMC_WAKING;
    assign SUPPLEMENT_FET_ON = fet_r && INPUT_VALID;
    assign RAIL_ENABLE = rail_r;
    // charge gating by pin and inhibit bit
    assign CHARGE_ENABLE = INPUT_VALID && !CHARGE_DISABLE_N && !CHARGE_INHIBIT
                           && state_r == PMC_ACTIVE;
    // aux switch in high-z follows control or earlier bus enable
    assign AUX_SWITCH_OUTPUT = HIGH_Z_MODE ? (AUX_OUTPUT_CONTROL || aux_latched_r)
                                           : AUX_BUS_ENABLE;
    // bus available only after exit completes, outside quiet, and not while the high-z bit holds it off
    assign SERIAL_ENABLE = !serial_off_r && !SHIP_MODE && state_r != PMC_QUIET;
    assign HOST_IF_READY = host_done;
    assign SAMPLE_BUSY = state_r == PMC_SAMPLE;
    assign CELL_LEVEL_FIELD = level_r;
endmodule : pmc_ctrl

// ### tb/pmc_ctrl_assertions.sv
`timescale 1ns/1ps
// port-level checks on the power mode controller
module pmc_ctrl_assertions (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic INPUT_VALID,
    input wire logic CHARGE_DISABLE_N,
    input wire logic PUSHBUTTON_N,
    input wire logic CHARGE_INHIBIT,
    input wire logic SHIP_REQUEST_SET,
    input wire logic SHIP_REQUEST_CLR,
    input wire logic SHIP_REQUEST_BIT,
    input wire logic SHIP_MODE,
    input wire logic HIGH_Z_MODE,
    input wire logic MID_PULLDOWN,
    input wire logic DISCHARGE_FET_ON,
    input wire logic CHARGE_ENABLE,
    input wire logic AUX_OUTPUT_CONTROL,
    input wire logic AUX_SWITCH_OUTPUT,
    input wire logic SHORT_LIMIT,
    input wire logic CELL_ABOVE_CUTOFF,
    input wire logic SAMPLE_BUSY
);
    logic [3:0] low_cnt_r;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // counts cycles of a low cell with no adapter, saturating
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            low_cnt_r <= 4'h0;
        end else if (CELL_ABOVE_CUTOFF || INPUT_VALID) begin
            low_cnt_r <= 4'h0;
        end else if (low_cnt_r != 4'hf) begin
            low_cnt_r <= low_cnt_r + 4'h1;
        end
    end
    // pull-down while latched off, cell path only while waking
    property p_ship_off; SHIP_MODE |-> MID_PULLDOWN != DISCHARGE_FET_ON; endproperty
    a_ship_off: assert property (p_ship_off) else $error("ship pull-down and cell path clash");
    property p_no_ship_in; $rose(SHIP_MODE) |-> !$past(INPUT_VALID); endproperty
    a_no_ship_in: assert property (p_no_ship_in) else $error("ship entered with input");
    property p_pins_high; $rose(SHIP_MODE) |-> $past(CHARGE_DISABLE_N) && $past(PUSHBUTTON_N);
    endproperty
    a_pins_high: assert property (p_pins_high) else $error("ship entered with pin low");
    property p_bit_set; SHIP_REQUEST_SET && INPUT_VALID |=> SHIP_REQUEST_BIT; endproperty
    a_bit_set: assert property (p_bit_set) else $error("ship bit not set");
    property p_bit_clr;
        SHIP_REQUEST_CLR && !SHIP_REQUEST_SET && INPUT_VALID |=> !SHIP_REQUEST_BIT;
    endproperty
    a_bit_clr: assert property (p_bit_clr) else $error("ship bit not cleared");
    property p_chg; CHARGE_ENABLE |-> INPUT_VALID && !CHARGE_DISABLE_N && !CHARGE_INHIBIT;
    endproperty
    a_chg: assert property (p_chg) else $error("charge on while disabled");
    property p_aux; HIGH_Z_MODE && AUX_OUTPUT_CONTROL |-> AUX_SWITCH_OUTPUT; endproperty
    a_aux: assert property (p_aux) else $error("aux output not following control");
    property p_rec; $fell(DISCHARGE_FET_ON) && SHORT_LIMIT && !SHIP_MODE |-> !DISCHARGE_FET_ON[*8];
    endproperty
    a_rec: assert property (p_rec) else $error("short recovery too short");
    property p_cut; low_cnt_r >= 4'hc |-> !DISCHARGE_FET_ON; endproperty
    a_cut: assert property (p_cut) else $error("cell path on below cutoff");
    property p_smp; $rose(SAMPLE_BUSY) |-> ##[1:16] !SAMPLE_BUSY; endproperty
    a_smp: assert property (p_smp) else $error("sample not finished in time");
endmodule : pmc_ctrl_assertions

bind pmc_ctrl pmc_ctrl_assertions chk_u (.CLK, .RSTN, .INPUT_VALID, .CHARGE_DISABLE_N,
    .PUSHBUTTON_N, .CHARGE_INHIBIT, .SHIP_REQUEST_SET, .SHIP_REQUEST_CLR, .SHIP_REQUEST_BIT,
    .SHIP_MODE, .HIGH_Z_MODE, .MID_PULLDOWN, .DISCHARGE_FET_ON, .CHARGE_ENABLE,
    .AUX_OUTPUT_CONTROL, .AUX_SWITCH_OUTPUT, .SHORT_LIMIT, .CELL_ABOVE_CUTOFF, .SAMPLE_BUSY);

// ### tb/pmc_pins_model.sv
`timescale 1ns/1ps
// host-side pins: button and charge-disable, changed only after a clock edge
module pmc_pins_model (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic press,
    input wire logic cd_high,
    output logic PUSHBUTTON_N,
    output logic CHARGE_DISABLE_N
);
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            PUSHBUTTON_N <= 1'b1;
            CHARGE_DISABLE_N <= 1'b0; // internal pull-down level
        end else begin
            PUSHBUTTON_N <= !press;
            CHARGE_DISABLE_N <= cd_high;
        end
    end
endmodule : pmc_pins_model

// ### tb/pmc_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module pmc_ctrl_tb;
    import pmc_pkg::*;
    localparam int DIV = 4;
    localparam int REC = 4;
    logic CLK = 0, RSTN = 0, INPUT_VALID = 1, INPUT_ABOVE_SLEEP = 1, press = 0, cd_high = 0;
    logic BUTTON_ACTION_SELECT = 0, LONG_PRESS_DONE = 0, SHIP_REQUEST_SET = 0;
    logic SHIP_REQUEST_CLR = 0, HIGH_Z_REQUEST_SET = 0, CHARGE_INHIBIT = 0, AUX_BUS_ENABLE = 0;
    logic AUX_OUTPUT_CONTROL = 0, CELL_ABOVE_CUTOFF = 1, CELL_ABOVE_RELEASE = 1;
    logic CELL_ABOVE_MIN_CUTOFF = 1, CELL_ABOVE_MAX_CUTOFF = 1, SHORT_LIMIT = 0;
    logic RAIL_IN_LEVEL = 1, CELL_SAMPLE_TRIGGER = 0, PUSHBUTTON_N, CHARGE_DISABLE_N;
    logic [TMR_W-1:0] WAKE1_MS = 12'h050;
    logic [LVL_W-1:0] CELL_LEVEL_IN = 5'h00, CELL_LEVEL_FIELD;
    logic SHIP_REQUEST_BIT, SHIP_MODE, HIGH_Z_MODE, MID_PULLDOWN, DISCHARGE_FET_ON;
    logic SUPPLEMENT_FET_ON, RAIL_ENABLE, CHARGE_ENABLE, AUX_SWITCH_OUTPUT, SERIAL_ENABLE;
    logic HOST_IF_READY, SAMPLE_BUSY;
    int failures = 0, n_tests = 0;
    logic [31:0] seed = 32'hb17885cb;
    logic [LVL_W-1:0] lvl_q[$];

    pmc_ctrl #(.REC_TICKS(REC), .DIV(DIV)) dut_u (.CLK(CLK), .RSTN(RSTN),
        .INPUT_VALID(INPUT_VALID), .INPUT_ABOVE_SLEEP(INPUT_ABOVE_SLEEP),
        .CHARGE_DISABLE_N(CHARGE_DISABLE_N), .PUSHBUTTON_N(PUSHBUTTON_N),
        .BUTTON_ACTION_SELECT(BUTTON_ACTION_SELECT), .LONG_PRESS_DONE(LONG_PRESS_DONE),
        .WAKE1_MS(WAKE1_MS), .SHIP_REQUEST_SET(SHIP_REQUEST_SET),
        .SHIP_REQUEST_CLR(SHIP_REQUEST_CLR), .HIGH_Z_REQUEST_SET(HIGH_Z_REQUEST_SET),
        .CHARGE_INHIBIT(CHARGE_INHIBIT), .AUX_BUS_ENABLE(AUX_BUS_ENABLE),
        .AUX_OUTPUT_CONTROL(AUX_OUTPUT_CONTROL), .CELL_ABOVE_CUTOFF(CELL_ABOVE_CUTOFF),
        .CELL_ABOVE_RELEASE(CELL_ABOVE_RELEASE), .CELL_ABOVE_MIN_CUTOFF(CELL_ABOVE_MIN_CUTOFF),
        .CELL_ABOVE_MAX_CUTOFF(CELL_ABOVE_MAX_CUTOFF), .SHORT_LIMIT(SHORT_LIMIT),
        .RAIL_IN_LEVEL(RAIL_IN_LEVEL), .CELL_SAMPLE_TRIGGER(CELL_SAMPLE_TRIGGER),
        .CELL_LEVEL_IN(CELL_LEVEL_IN), .SHIP_REQUEST_BIT(SHIP_REQUEST_BIT),
        .SHIP_MODE(SHIP_MODE), .HIGH_Z_MODE(HIGH_Z_MODE), .MID_PULLDOWN(MID_PULLDOWN),
        .DISCHARGE_FET_ON(DISCHARGE_FET_ON), .SUPPLEMENT_FET_ON(SUPPLEMENT_FET_ON),
        .RAIL_ENABLE(RAIL_ENABLE), .CHARGE_ENABLE(CHARGE_ENABLE),
        .AUX_SWITCH_OUTPUT(AUX_SWITCH_OUTPUT), .SERIAL_ENABLE(SERIAL_ENABLE),
        .HOST_IF_READY(HOST_IF_READY), .SAMPLE_BUSY(SAMPLE_BUSY),
        .CELL_LEVEL_FIELD(CELL_LEVEL_FIELD));
    pmc_pins_model pins_u (.CLK(CLK), .RSTN(RSTN), .press(press), .cd_high(cd_high),
        .PUSHBUTTON_N(PUSHBUTTON_N), .CHARGE_DISABLE_N(CHARGE_DISABLE_N));

    // 250 MHz clock
    always #2 CLK = ~CLK;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic pick(input int s);
        case (s)
            0: return SHIP_MODE;
            1: return SAMPLE_BUSY;
            2: return HIGH_Z_MODE;
            default: return DISCHARGE_FET_ON;
        endcase
    endfunction : pick

    // bounded wait for a watched output to reach a level
    task automatic wait_sig(input int s, input logic lvl);
        int n;
        n = 0;
        while (pick(s) !== lvl && n < 400) begin
            @(posedge CLK);
            #1;
            n++;
        end
        `CHK(pick(s), lvl)
    endtask : wait_sig

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test

    // watchdog
    initial begin
        repeat (20000) @(posedge CLK);
        failures++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge CLK);
        RSTN <= 1'b1;
        @(posedge CLK);
        #1;
        `CHK(SHIP_MODE, 1'b0)
        `CHK(CELL_LEVEL_FIELD, LVL_RST)
        // charge enable table, pin and inhibit bit
        for (int i = 0; i < 4; i++) begin
            @(posedge CLK);
            cd_high <= i[0];
            CHARGE_INHIBIT <= i[1];
            repeat (3) @(posedge CLK);
            #1;
            `CHK(CHARGE_ENABLE, logic'(i == 0))
        end
        `CHK(SUPPLEMENT_FET_ON, 1'b1)
        $display("test charge_table done");
        // ship bit with adapter present: refused, cleared, armed for removal
        @(posedge CLK);
        CHARGE_INHIBIT <= 1'b0;
        SHIP_REQUEST_SET <= 1'b1;
        @(posedge CLK);
        SHIP_REQUEST_SET <= 1'b0;
        repeat (20) @(posedge CLK);
        #1;
        `CHK(SHIP_MODE, 1'b0)
        `CHK(SHIP_REQUEST_BIT, 1'b1)
        `CHK(HOST_IF_READY, 1'b1)
        @(posedge CLK);
        SHIP_REQUEST_CLR <= 1'b1;
        @(posedge CLK);
        SHIP_REQUEST_CLR <= 1'b0;
        @(posedge CLK);
        #1;
        `CHK(SHIP_REQUEST_BIT, 1'b0)
        @(posedge CLK);
        SHIP_REQUEST_SET <= 1'b1;
        cd_high <= 1'b1;
        @(posedge CLK);
        SHIP_REQUEST_SET <= 1'b0;
        INPUT_VALID <= 1'b0;
        INPUT_ABOVE_SLEEP <= 1'b0;
        wait_sig(0, 1'b1);
        `CHK(MID_PULLDOWN, 1'b1)
        `CHK(DISCHARGE_FET_ON, 1'b0)
        `CHK(SERIAL_ENABLE, 1'b0)
        `CHK(RAIL_ENABLE, 1'b0)
        $display("test ship_entry done");
        // button exit after the wake1 hold
        repeat (30) @(posedge CLK);
        #1;
        `CHK(SHIP_MODE, 1'b1)
        @(posedge CLK);
        press <= 1'b1;
        repeat (40) @(posedge CLK);
        #1;
        `CHK(DISCHARGE_FET_ON, 1'b1)
        repeat (360) @(posedge CLK);
        press <= 1'b0;
        repeat (4) @(posedge CLK);
        #1;
        `CHK(SHIP_MODE, 1'b0)
        `CHK(SERIAL_ENABLE, 1'b1)
        `CHK(RAIL_ENABLE, 1'b1)
        $display("test ship_exit done");
        // sampling with random levels, charge held off by the pin
        for (int k = 0; k < 3; k++) begin
            @(posedge CLK);
            seed = lfsr(seed);
            CELL_LEVEL_IN <= LVL_W'(seed[7:0] % 21);
            lvl_q.push_back(LVL_W'(seed[7:0] % 21));
            CELL_SAMPLE_TRIGGER <= 1'b1; // charge off first
            @(posedge CLK);
            CELL_SAMPLE_TRIGGER <= 1'b0;
            @(posedge CLK);
            #1;
            wait_sig(1, 1'b0);
            `CHK(CELL_LEVEL_FIELD, lvl_q.pop_front())
        end
        $display("test sample done");
        // held short: off for the recovery time, then retry
        @(posedge CLK);
        SHORT_LIMIT <= 1'b1;
        wait_sig(3, 1'b0);
        repeat (REC * DIV - 4) @(posedge CLK);
        #1;
        `CHK(DISCHARGE_FET_ON, 1'b0)
        @(posedge CLK);
        SHORT_LIMIT <= 1'b0;
        wait_sig(3, 1'b1);
        $display("test short done");
        // high impedance by pin low, aux output follows its control
        @(posedge CLK);
        cd_high <= 1'b0;
        wait_sig(2, 1'b1);
        for (int i = 0; i < 2; i++) begin
            @(posedge CLK);
            AUX_OUTPUT_CONTROL <= i[0];
            @(posedge CLK);
            #1;
            `CHK(AUX_SWITCH_OUTPUT, i[0])
        end
        @(posedge CLK);
        cd_high <= 1'b1;
        wait_sig(2, 1'b0);
        $display("test high_z done");
        // high-z bit with cell only: bus off until a pin toggle, aux kept on
        @(posedge CLK);
        AUX_BUS_ENABLE <= 1'b1;
        AUX_OUTPUT_CONTROL <= 1'b0;
        HIGH_Z_REQUEST_SET <= 1'b1;
        @(posedge CLK);
        HIGH_Z_REQUEST_SET <= 1'b0;
        @(posedge CLK);
        #1;
        `CHK(SERIAL_ENABLE, 1'b0)
        wait_sig(2, 1'b1);
        @(posedge CLK);
        AUX_BUS_ENABLE <= 1'b0;
        @(posedge CLK);
        #1;
        `CHK(AUX_SWITCH_OUTPUT, 1'b1)
        @(posedge CLK);
        cd_high <= 1'b0;
        @(posedge CLK);
        cd_high <= 1'b1;
        wait_sig(2, 1'b0);
        repeat (2) @(posedge CLK);
        #1;
        `CHK(SERIAL_ENABLE, 1'b1)
        $display("test high_z_bit done");
        // cutoff with hysteresis on release
        @(posedge CLK);
        CELL_ABOVE_CUTOFF <= 1'b0;
        CELL_ABOVE_RELEASE <= 1'b0;
        wait_sig(3, 1'b0);
        @(posedge CLK);
        CELL_ABOVE_CUTOFF <= 1'b1;
        repeat (20) @(posedge CLK);
        #1;
        `CHK(DISCHARGE_FET_ON, 1'b0)
        @(posedge CLK);
        CELL_ABOVE_RELEASE <= 1'b1;
        wait_sig(3, 1'b1);
        $display("test cutoff done");
        // long press: refused with action select 1, armed by an adapter with select 0
        @(posedge CLK);
        BUTTON_ACTION_SELECT <= 1'b1;
        LONG_PRESS_DONE <= 1'b1;
        repeat (20) @(posedge CLK);
        #1;
        `CHK(SHIP_MODE, 1'b0)
        @(posedge CLK);
        BUTTON_ACTION_SELECT <= 1'b0;
        INPUT_VALID <= 1'b1;
        press <= 1'b1;
        repeat (4) @(posedge CLK);
        press <= 1'b0;
        LONG_PRESS_DONE <= 1'b0;
        INPUT_VALID <= 1'b0;
        wait_sig(0, 1'b1);
        `CHK(MID_PULLDOWN, 1'b1)
        $display("test long_press done");
        finish_test();
    end
endmodule : pmc_ctrl_tb
